// *** inc/gpio_port_map.vh ***
/*
  Register offsets, control bit positions and reset values of the dual port
  block with its parallel slave select. Included by the design files only.
*/
`ifndef GPIO_PORT_MAP_VH
`define GPIO_PORT_MAP_VH

// Register offsets on the plain register port
`define WIDE_PINS_OFS       4'h0
`define WIDE_LATCH_OFS      4'h1
`define WIDE_DIR_OFS        4'h2
`define NARROW_PINS_OFS     4'h3
`define NARROW_LATCH_OFS    4'h4
`define NARROW_DIR_OFS      4'h5
`define ANALOG_SEL_OFS      4'h6

// Narrow direction and slave control register fields
`define CTL_IN_FULL         7
`define CTL_OUT_FULL        6
`define CTL_OVERRUN         5
`define CTL_SLAVE_SEL       4
`define CTL_DIR_HI          2
`define CTL_DIR_LO          0

// Narrow pin roles in slave mode
`define STROBE_RD           0
`define STROBE_WR           1
`define STROBE_CS           2

// Reset values
`define WIDE_DIR_RESET      8'hFF
`define NARROW_DIR_RESET    3'h7
`define ANALOG_SEL_RESET    3'h0
`define READ_ZERO           8'h00

`endif

// *** logic/pin_sync.v ***
/*
  Two flip-flop synchroniser for a group of pin inputs.
  Assumes a free-running clock and a clock enable shared with the parent.
*/
`timescale 1ns/1ps

module pin_sync #(
  parameter WIDTH = 8
) (
  // Clock
  input  wire             sys_clk,
  input  wire             ce,
  // Pins in, synchronised out
  input  wire [WIDTH-1:0] pin_in,
  output reg  [WIDTH-1:0] pin_sync_q
);

  reg [WIDTH-1:0] meta_q;

  // First stage is read by the second stage only
  always @(posedge sys_clk)
  begin
    if (ce)
    begin
      meta_q     <= pin_in;
      pin_sync_q <= meta_q;
    end
  end

endmodule

// *** logic/dual_gpio_port.v ***
/*
  Dual general purpose port: an 8-bit wide port and a 3-bit narrow port,
  each with pin, latch and direction registers, plus the slave mode select
  that turns the wide port into a microprocessor data port strobed by the
  narrow pins.
  Register map: 0 wide pins, 1 wide latch, 2 wide direction, 3 narrow pins,
  4 narrow latch, 5 narrow direction and slave control, 6 analog select.
  Read data stand for one cycle after the read strobe, zero otherwise.
  Assumes pins arrive asynchronously and a single sys_clk. Pin reads lag
  the pins by the two synchroniser stages. Latches and the captured word
  have no reset, so software writes the latches before enabling drivers.
  Slave strobes must stay low for at least three clocks to be seen, and
  the host must hold the data pins for the whole write strobe.
*/
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "gpio_port_map.vh"

module dual_gpio_port #(
  parameter WIDE_W   = 8,
  parameter NARROW_W = 3
) (
  // Clock, reset, enable
  input  wire                sys_clk,
  input  wire                reset_n,
  input  wire                ce,
  // Register port
  input  wire [3:0]          reg_addr,
  input  wire [7:0]          reg_wdata,
  input  wire                reg_wr,
  input  wire                reg_rd,
  output reg  [7:0]          reg_rdata,
  // Wide port pins
  input  wire [WIDE_W-1:0]   wide_pin_in,
  output wire [WIDE_W-1:0]   wide_pin_out,
  output wire [WIDE_W-1:0]   wide_pin_oe,
  // Narrow port pins
  input  wire [NARROW_W-1:0] narrow_pin_in,
  output wire [NARROW_W-1:0] narrow_pin_out,
  output wire [NARROW_W-1:0] narrow_pin_oe,
  // Input buffer threshold select, high for TTL
  output wire                wide_ttl_select
);

  wire [WIDE_W-1:0]   wide_sync;
  wire [NARROW_W-1:0] narrow_sync;
  wire [NARROW_W-1:0] narrow_view;

  reg  [WIDE_W-1:0]   wide_latch_q;
  reg  [WIDE_W-1:0]   wide_latch_d;
  reg  [NARROW_W-1:0] narrow_latch_q;
  reg  [NARROW_W-1:0] narrow_latch_d;
  reg  [WIDE_W-1:0]   wide_dir_q;
  reg  [WIDE_W-1:0]   wide_dir_d;
  reg  [NARROW_W-1:0] narrow_dir_q;
  reg  [NARROW_W-1:0] narrow_dir_d;
  reg  [NARROW_W-1:0] analog_sel_q;
  reg  [NARROW_W-1:0] analog_sel_d;
  reg                 slave_sel_q;
  reg                 slave_sel_d;
  reg                 in_full_q;
  reg                 in_full_d;
  reg                 out_full_q;
  reg                 out_full_d;
  reg                 overrun_q;
  reg                 overrun_d;
  reg  [WIDE_W-1:0]   in_word_q;
  reg                 wr_act_q;
  reg                 rd_act_q;
  reg  [7:0]          rdata_d;
  reg  [7:0]          ctl_view;

  pin_sync #(
    .WIDTH (WIDE_W)
  ) u_wide_sync (
    .sys_clk    (sys_clk),
    .ce         (ce),
    .pin_in     (wide_pin_in),
    .pin_sync_q (wide_sync)
  );

  pin_sync #(
    .WIDTH (NARROW_W)
  ) u_narrow_sync (
    .sys_clk    (sys_clk),
    .ce         (ce),
    .pin_in     (narrow_pin_in),
    .pin_sync_q (narrow_sync)
  );

  wire cs_act = slave_sel_q & ~narrow_sync[`STROBE_CS];
  wire wr_act = cs_act & ~narrow_sync[`STROBE_WR];
  wire rd_act = cs_act & ~narrow_sync[`STROBE_RD];
  // Flags move when the strobe ends, so the captured word has settled.
  // Leaving slave mode mid-strobe must not look like a strobe end,
  // otherwise a half-captured word would raise the input flag.
  wire wr_end = wr_act_q & ~wr_act & slave_sel_q;
  wire rd_end = rd_act_q & ~rd_act & slave_sel_q;

  wire wr_wide_pins   = reg_wr & (reg_addr == `WIDE_PINS_OFS);
  wire wr_wide_latch  = reg_wr & (reg_addr == `WIDE_LATCH_OFS);
  wire wr_narrow_pins = reg_wr & (reg_addr == `NARROW_PINS_OFS);
  wire wr_narrow_lat  = reg_wr & (reg_addr == `NARROW_LATCH_OFS);
  wire wr_ctl         = reg_wr & (reg_addr == `NARROW_DIR_OFS);
  wire rd_wide_pins   = reg_rd & (reg_addr == `WIDE_PINS_OFS);

  assign wide_ttl_select = slave_sel_q;

  // slave data bit n on wide pin n
  assign wide_pin_out = wide_latch_q;
  genvar gi;
  generate
    for (gi = 0; gi < WIDE_W; gi = gi + 1)
    begin : g_wide_oe
      // plain direction control when slave select clear
      assign wide_pin_oe[gi] = slave_sel_q ? rd_act : ~wide_dir_q[gi];
    end
    for (gi = 0; gi < NARROW_W; gi = gi + 1)
    begin : g_narrow_oe
      // narrow pin driven only when direction bit clear
      // slave mode releases narrow pins as strobe inputs
      assign narrow_pin_oe[gi] = ~slave_sel_q & ~narrow_dir_q[gi];
    end
    // analog-selected narrow pins read as zero
    for (gi = 0; gi < NARROW_W; gi = gi + 1)
    begin : g_narrow_view
      assign narrow_view[gi] = narrow_sync[gi] & ~analog_sel_q[gi];
    end
  endgenerate
  assign narrow_pin_out = narrow_latch_q;

  // Latches: pin writes land in latch
  always @*
  begin
    wide_latch_d   = wide_latch_q;
    narrow_latch_d = narrow_latch_q;
    if (wr_wide_pins | wr_wide_latch)
      wide_latch_d = reg_wdata[WIDE_W-1:0];
    if (wr_narrow_pins | wr_narrow_lat)
      narrow_latch_d = reg_wdata[NARROW_W-1:0];
  end

  // latches and input word untouched by reset
  always @(posedge sys_clk)
  begin
    if (ce)
    begin
      wide_latch_q   <= wide_latch_d;
      narrow_latch_q <= narrow_latch_d;
      if (wr_act)
        in_word_q <= wide_sync;
    end
  end

  // Configuration next state
  always @*
  begin
    wide_dir_d   = wide_dir_q;
    narrow_dir_d = narrow_dir_q;
    analog_sel_d = analog_sel_q;
    slave_sel_d  = slave_sel_q;
    if (reg_wr & (reg_addr == `WIDE_DIR_OFS))
      wide_dir_d = reg_wdata[WIDE_W-1:0];
    if (reg_wr & (reg_addr == `ANALOG_SEL_OFS))
      analog_sel_d = reg_wdata[NARROW_W-1:0];
    if (wr_ctl)
    begin
      narrow_dir_d = reg_wdata[`CTL_DIR_HI:`CTL_DIR_LO];
      slave_sel_d  = reg_wdata[`CTL_SLAVE_SEL];
    end
  end

  // Status flags next state; hardware set events come last so that an
  // event and a software clear in one cycle leave the flag set
  always @*
  begin
    in_full_d  = in_full_q;
    out_full_d = out_full_q;
    overrun_d  = overrun_q;
    // software clears overrun by writing zero
    if (wr_ctl & ~reg_wdata[`CTL_OVERRUN])
      overrun_d = 1'b0;
    // cleared when the CPU takes the word
    if (rd_wide_pins & slave_sel_q)
      in_full_d = 1'b0;
    if (rd_end)
      out_full_d = 1'b0;
    if (wr_wide_pins & slave_sel_q)
      out_full_d = 1'b1;
    // new word over an unread one; set beats clear
    if (wr_end & in_full_q)
      overrun_d = 1'b1;
    // set wins over a same-cycle CPU read
    if (wr_end)
      in_full_d = 1'b1;
  end

  // Reset is taken only while enabled, so a frozen block stays frozen
  always @(posedge sys_clk)
  begin
    if (ce)
    begin
      if (!reset_n)
      begin
        // wide pins all inputs after reset
        wide_dir_q   <= `WIDE_DIR_RESET;
        // control register resets to 0000 -111
        narrow_dir_q <= `NARROW_DIR_RESET;
        analog_sel_q <= `ANALOG_SEL_RESET;
        slave_sel_q  <= 1'b0;
      end
      else
      begin
        wide_dir_q   <= wide_dir_d;
        narrow_dir_q <= narrow_dir_d;
        analog_sel_q <= analog_sel_d;
        slave_sel_q  <= slave_sel_d;
      end
    end
  end

  // Flags, strobe history and read data
  always @(posedge sys_clk)
  begin
    if (ce)
    begin
      if (!reset_n)
      begin
        in_full_q  <= 1'b0;
        out_full_q <= 1'b0;
        overrun_q  <= 1'b0;
        // Inactive history avoids a false strobe end after reset
        wr_act_q   <= 1'b0;
        rd_act_q   <= 1'b0;
        reg_rdata  <= `READ_ZERO;
      end
      else
      begin
        in_full_q  <= in_full_d;
        out_full_q <= out_full_d;
        overrun_q  <= overrun_d;
        wr_act_q   <= wr_act;
        rd_act_q   <= rd_act;
        reg_rdata  <= rdata_d;
      end
    end
  end

  // Read mux, answer stands in the following cycle only
  always @*
  begin
    ctl_view = `READ_ZERO;
    ctl_view[`CTL_IN_FULL]   = in_full_q;
    ctl_view[`CTL_OUT_FULL]  = out_full_q;
    ctl_view[`CTL_OVERRUN]   = overrun_q;
    ctl_view[`CTL_SLAVE_SEL] = slave_sel_q;
    ctl_view[`CTL_DIR_HI:`CTL_DIR_LO] = narrow_dir_q;
    rdata_d = `READ_ZERO;
    if (reg_rd)
    begin
      case (reg_addr)
        // pin register returns sampled pins; slave mode gives input word
        `WIDE_PINS_OFS:    rdata_d = slave_sel_q ? in_word_q : wide_sync;
        `WIDE_LATCH_OFS:   rdata_d = wide_latch_q;
        `WIDE_DIR_OFS:     rdata_d = wide_dir_q;
        `NARROW_PINS_OFS:  rdata_d[NARROW_W-1:0] = narrow_view;
        `NARROW_LATCH_OFS: rdata_d[NARROW_W-1:0] = narrow_latch_q;
        `NARROW_DIR_OFS:   rdata_d = ctl_view;
        `ANALOG_SEL_OFS:   rdata_d[NARROW_W-1:0] = analog_sel_q;
        // Unmapped offsets read zero and ignore writes
        default:           rdata_d = `READ_ZERO;
      endcase
    end
  end

endmodule

// *** verif/dual_gpio_port_assertions.sv ***
/* Port-level checker for dual_gpio_port.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module dual_gpio_port_assertions #(
  parameter WIDE_W   = 8,
  parameter NARROW_W = 3
) (
  // Clock and register port
  input wire                sys_clk,
  input wire                reset_n,
  input wire                ce,
  input wire [3:0]          reg_addr,
  input wire [7:0]          reg_wdata,
  input wire                reg_wr,
  input wire                reg_rd,
  input wire [7:0]          reg_rdata,
  // Pins
  input wire [WIDE_W-1:0]   wide_pin_out,
  input wire [WIDE_W-1:0]   wide_pin_oe,
  input wire [NARROW_W-1:0] narrow_pin_in,
  input wire [NARROW_W-1:0] narrow_pin_out,
  input wire [NARROW_W-1:0] narrow_pin_oe,
  input wire                wide_ttl_select
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_ctl_wr; ce && reg_wr && reg_addr == 4'h5; endsequence
  sequence s_ctl_rd; ce && reg_rd && reg_addr == 4'h5; endsequence
  // Slave read strobe: cs and rd low, wr high
  sequence s_rd_strobe; (wide_ttl_select && narrow_pin_in == 3'h2) [*3]; endsequence

  a_wide_dir: assert property ((ce && reg_wr && reg_addr == 4'h2 && !wide_ttl_select)
    |=> wide_pin_oe == ~$past(reg_wdata)) else $error("wide enable wrong");
  a_wide_latch: assert property ((ce && reg_wr && reg_addr <= 4'h1)
    |=> wide_pin_out == $past(reg_wdata)) else $error("wide latch wrong");
  a_narrow_latch: assert property ((ce && reg_wr && reg_addr inside {4'h3, 4'h4})
    |=> narrow_pin_out == $past(reg_wdata[2:0])) else $error("narrow latch wrong");
  a_read_idle: assert property ((ce && !reg_rd) |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_ctl_layout: assert property (s_ctl_wr ##2 s_ctl_rd
    |=> reg_rdata[4:0] == ($past(reg_wdata[4:0], 3) & 5'h17)) else $error("control layout");
  a_ttl_follow: assert property (s_ctl_wr |=> wide_ttl_select == $past(reg_wdata[4]))
    else $error("threshold select wrong");
  a_slave_ctl_in: assert property (wide_ttl_select |-> narrow_pin_oe == 3'h0)
    else $error("narrow pin driven in slave mode");
  a_slave_rd_drive: assert property (s_rd_strobe |-> wide_pin_oe == 8'hFF)
    else $error("slave read not driven");
  a_reset_state: assert property (@(posedge sys_clk) disable iff (1'b0)
    (!reset_n && ce) |=> (wide_pin_oe == 8'h00 && narrow_pin_oe == 3'h0 && !wide_ttl_select))
    else $error("reset state wrong");
endmodule

bind dual_gpio_port dual_gpio_port_assertions #(.WIDE_W(WIDE_W), .NARROW_W(NARROW_W)) u_chk (
  .sys_clk, .reset_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .wide_pin_out, .wide_pin_oe, .narrow_pin_in, .narrow_pin_out, .narrow_pin_oe,
  .wide_ttl_select);

// *** verif/port_pins_model.sv ***
/* Circuitry on the pins: drives them and acts as the slave bus host.
   Assumes high enable means the block drives the pin. */
`timescale 1ns/1ps
module port_pins_model (
  // Clock
  input  wire       sys_clk,
  // Block side of the pins
  input  wire [7:0] wide_pin_out,
  input  wire [7:0] wide_pin_oe,
  input  wire [2:0] narrow_pin_out,
  input  wire [2:0] narrow_pin_oe,
  // Resolved pin levels
  output wire [7:0] wide_pin_in,
  output wire [2:0] narrow_pin_in
);
  logic [7:0] ext_w  = 8'h00;
  logic [7:0] ext_we = 8'h00;
  logic [2:0] ext_n  = 3'h7;
  logic [2:0] ext_ne = 3'h0;
  logic       flt_q  = 1'b0;

  // Undriven pins toggle so no stale level passes
  always @(posedge sys_clk) flt_q <= ~flt_q;
  assign wide_pin_in = wide_pin_oe & wide_pin_out
    | ~wide_pin_oe & (ext_we & ext_w | ~ext_we & {8{flt_q}});
  assign narrow_pin_in = narrow_pin_oe & narrow_pin_out
    | ~narrow_pin_oe & (ext_ne & ext_n | ~ext_ne & {3{flt_q}});

  task automatic drive(input logic [7:0] w, we, input logic [2:0] n, ne);
    @(posedge sys_clk);
    ext_w <= w;
    ext_we <= we;
    ext_n <= n;
    ext_ne <= ne;
  endtask
  // strobes rd/wr/cs, data bit n on pin n
  task automatic host_write(input logic [7:0] d);
    drive(d, 8'hFF, 3'h1, 3'h7);
    repeat (4) @(posedge sys_clk);
    ext_n <= 3'h7;
    drive(d, 8'h00, 3'h7, 3'h7);
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic host_read(output logic [7:0] d);
    drive(8'h00, 8'h00, 3'h2, 3'h7);
    repeat (4) @(posedge sys_clk);
    d = wide_pin_in;
    ext_n <= 3'h7;
    repeat (5) @(posedge sys_clk);
  endtask
endmodule

// *** verif/dual_gpio_port_bench.sv ***
/* Self-checking bench for dual_gpio_port with the pin model.
   Assumes the register port timing of the block. */
`timescale 1ns/1ps
module dual_gpio_port_bench;
  logic       sys_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       ce      = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata, wide_pin_in, wide_pin_out, wide_pin_oe, rv;
  logic [2:0] narrow_pin_in, narrow_pin_out, narrow_pin_oe;
  logic       wide_ttl_select;
  int         errors = 0;
  int         check_count = 0;

  always #20 sys_clk = ~sys_clk;
  dual_gpio_port i_dual_gpio_port (.sys_clk, .reset_n, .ce, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .wide_pin_in, .wide_pin_out, .wide_pin_oe,
    .narrow_pin_in, .narrow_pin_out, .narrow_pin_oe, .wide_ttl_select);
  port_pins_model i_port_pins_model (.sys_clk, .wide_pin_out, .wide_pin_oe,
    .narrow_pin_out, .narrow_pin_oe, .wide_pin_in, .narrow_pin_in);

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input string nm, input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(nm, reg_rdata, exp);
  endtask
  task automatic t_wide();
    rd("wdir", 4'h2, 8'hFF);
    rd("ctl", 4'h5, 8'h07);
    chk("ttl", {7'h00, wide_ttl_select}, 8'h00);
    wr(4'h0, 8'hA5);
    rd("wlat", 4'h1, 8'hA5);
    wr(4'h1, 8'h96);
    chk("wout", wide_pin_out, 8'h96);
    wr(4'h2, 8'h0F);
    chk("woe", wide_pin_oe, 8'hF0);
    i_port_pins_model.drive(8'h0C, 8'h0F, 3'h2, 3'h3);
    repeat (3) @(posedge sys_clk);
    rd("wpins", 4'h0, 8'h9C);
    rd("wlat", 4'h1, 8'h96);
  endtask
  task automatic t_narrow();
    wr(4'h4, 8'h05);
    chk("nout", {5'h00, narrow_pin_out}, 8'h05);
    wr(4'h5, 8'h03);
    chk("noe", {5'h00, narrow_pin_oe}, 8'h04);
    // Newly driven pin needs both synchroniser stages
    repeat (2) @(posedge sys_clk);
    rd("npins", 4'h3, 8'h06);
    wr(4'h6, 8'h03);
    rd("analog", 4'h3, 8'h04);
    rd("nlat", 4'h4, 8'h05);
    wr(4'h9, 8'hFF);
    rd("unmapped", 4'h9, 8'h00);
    wr(4'h6, 8'h00);
  endtask
  task automatic t_slave();
    i_port_pins_model.drive(8'h00, 8'h00, 3'h7, 3'h7);
    wr(4'h5, 8'h17);
    chk("ttl", {7'h00, wide_ttl_select}, 8'h01);
    chk("noe", {5'h00, narrow_pin_oe}, 8'h00);
    rd("ctl", 4'h5, 8'h17);
    i_port_pins_model.host_write(8'h3C);
    rd("ctl", 4'h5, 8'h97);
    rd("word", 4'h0, 8'h3C);
    rd("ctl", 4'h5, 8'h17);
    i_port_pins_model.host_write(8'h11);
    i_port_pins_model.host_write(8'h22);
    rd("ctl", 4'h5, 8'hB7);
    wr(4'h5, 8'h17);
    rd("ctl", 4'h5, 8'h97);
    wr(4'h0, 8'h5A);
    rd("ctl", 4'h5, 8'hD7);
    i_port_pins_model.host_read(rv);
    chk("hostrd", rv, 8'h5A);
    rd("ctl", 4'h5, 8'h97);
    wr(4'h5, 8'h07);
    chk("ttl", {7'h00, wide_ttl_select}, 8'h00);
  endtask
  task automatic t_reset();
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd("ctl", 4'h5, 8'h07);
    rd("wdir", 4'h2, 8'hFF);
    chk("woe", wide_pin_oe, 8'h00);
    rd("wlat", 4'h1, 8'h5A);
    rd("nlat", 4'h4, 8'h05);
  endtask
  task automatic t_freeze();
    @(posedge sys_clk);
    ce <= 1'b0;
    wr(4'h1, 8'h33);
    wr(4'h2, 8'h00);
    chk("woe", wide_pin_oe, 8'h00);
    @(posedge sys_clk);
    ce <= 1'b1;
    rd("wlat", 4'h1, 8'h5A);
    rd("wdir", 4'h2, 8'hFF);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_wide();
    t_narrow();
    t_slave();
    t_reset();
    t_freeze();
    test_done();
  end
  // Whole run is well under two hundred cycles
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    test_done();
  end
endmodule
